// >>> rtl/tsa_map.vh
`ifndef TSA_MAP_VH
`define TSA_MAP_VH

// Register indices; byte address is four times the index
`define TSA_IDX_EXT_TEMP     14'h2900
`define TSA_IDX_SRC_SEL      14'h2902
`define TSA_IDX_LOW_THR      14'h2903
`define TSA_IDX_HIGH_THR     14'h2905
`define TSA_IDX_LIVE_STAT    14'h3002
`define TSA_IDX_DIE_TEMP     14'h3003
`define TSA_IDX_IRQ_STAT     14'h300c
`define TSA_IDX_IRQ_MASK     14'h2910
`define TSA_IDX_COEF0        14'h2920
`define TSA_IDX_COEF1        14'h2921
`define TSA_IDX_COEF2        14'h2922
`define TSA_IDX_COEF3        14'h2923
`define TSA_IDX_COEF4        14'h2924
`define TSA_IDX_COEF5        14'h2925
`define TSA_IDX_DESIGNATE    14'h2930
`define TSA_IDX_TUNING       14'h2931
`define TSA_IDX_COMP_TERM    14'h3040
`define TSA_IDX_PERIOD_ERR   14'h3041

// Field positions
`define TSA_SEL_SYS_BIT      0
`define TSA_SEL_LOOP1_BIT    1
`define TSA_SEL_LOOP2_BIT    2
`define TSA_LIVE_ALARM_BIT   0
`define TSA_IRQ_TEMP_BIT     4
`define TSA_DES_NCO_BIT      0
`define TSA_DES_TDC_BIT      1

// Reset values
`define TSA_RST_SRC_SEL      3'h0
`define TSA_RST_LOW_THR      16'h8000
`define TSA_RST_HIGH_THR     16'h7fff
`define TSA_RST_EXT_TEMP     16'h0000

// Formats and timing
`define TSA_TEMP_FRAC        7
`define TSA_COMP_FRAC        31
`define TSA_POLY_ORDER       5
`define TSA_CLK_MHZ          100
`define TSA_SAMPLE_MHZ       25
`define TSA_AVG_LOG2         12
`define TSA_AVG_COUNT        4096

`endif

// >>> rtl/tsa_poly_eval.v
`timescale 1ns/10ps
`include "tsa_map.vh"

// Horner evaluation, one power of temperature per clock
module tsa_poly_eval (
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        start_i,
    input  wire [15:0] temp_i,
    input  wire [31:0] c0_i,
    input  wire [31:0] c1_i,
    input  wire [31:0] c2_i,
    input  wire [31:0] c3_i,
    input  wire [31:0] c4_i,
    input  wire [31:0] c5_i,
    output reg  [31:0] result_o,
    output reg         done_o
);
    reg        [31:0] acc_reg;
    reg        [15:0] temp_reg;
    reg        [2:0]  step_reg;
    reg               busy_reg;
    reg        [31:0] coef;
    wire signed [47:0] prod;

    assign prod = $signed(acc_reg) * $signed(temp_reg);

    always @* begin
        case (step_reg)
            3'h4:    coef = c4_i;
            3'h3:    coef = c3_i;
            3'h2:    coef = c2_i;
            3'h1:    coef = c1_i;
            default: coef = c0_i;
        endcase
    end

    // A new start restarts the walk so the latest temperature always wins
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_reg  <= 32'h00000000;
            temp_reg <= 16'h0000;
            step_reg <= 3'h0;
            busy_reg <= 1'b0;
            result_o <= 32'h00000000;
            done_o   <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                acc_reg  <= c5_i;
                temp_reg <= temp_i;
                step_reg <= 3'h4;
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                acc_reg <= prod[31+`TSA_TEMP_FRAC:`TSA_TEMP_FRAC] + coef;
                if (step_reg == 3'h0) begin
                    busy_reg <= 1'b0;
                    done_o   <= 1'b1;
                    result_o <= prod[31+`TSA_TEMP_FRAC:`TSA_TEMP_FRAC] + coef;
                end else begin
                    step_reg <= step_reg - 3'h1;
                end
            end
        end
    end
endmodule

// >>> rtl/tsa_temp_comp.v
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps
`include "tsa_map.vh"

// Summary of operation
// - Two sources: die sensor or external register
// - Select bits route sys, loop1, loop2 independently
// - Zero picks sensor, one picks external; reset zero
// - Sensor value signed, 1/128 degree, readable
// - Sample 25 MHz, average 4096, then refresh
// - Signed high and low limits, sensor format
// - Live alarm while reading outside limits
// - Live alarm feeds interrupt status bit four
// - Sensor readings passed in consumer scale
// - Correction as fractional frequency error term
// - Period error is minus term over one plus
// - Fifth order polynomial plus constant offset
// - Correction only to designated NCO and TDC
// - NCO rate scaled by one plus term
module tsa_temp_comp (
    input  wire        REF_CLK_I,
    input  wire        RESETN_I,
    input  wire        HSEL_I,
    input  wire [31:0] HADDR_I,
    input  wire [1:0]  HTRANS_I,
    input  wire        HWRITE_I,
    input  wire [2:0]  HSIZE_I,
    input  wire [31:0] HWDATA_I,
    input  wire        HREADY_I,
    output reg  [31:0] HRDATA_O,
    output reg         HREADYOUT_O,
    output reg         HRESP_O,
    input  wire [15:0] SENSOR_DATA_I,
    output reg  [15:0] SYS_TEMP_O,
    output reg  [15:0] LOOP1_TEMP_O,
    output reg  [15:0] LOOP2_TEMP_O,
    output reg         TEMP_ALARM_O,
    output reg         IRQ_O,
    output reg  [31:0] COMP_TERM_O,
    output reg         COMP_VALID_O,
    output reg  [31:0] NCO_TUNING_O,
    output reg  [31:0] TDC_CORR_O
);
    localparam integer SAMPLE_DIV_INT = `TSA_CLK_MHZ / `TSA_SAMPLE_MHZ - 1;
    localparam integer AVG_LAST_INT   = `TSA_AVG_COUNT - 1;
    localparam [7:0]   SAMPLE_DIV_M1  = SAMPLE_DIV_INT[7:0];
    localparam [11:0]  AVG_LAST       = AVG_LAST_INT[11:0];

    // Q31 signed multiply
    function [31:0] q31_mul;
        input [31:0] a;
        input [31:0] b;
        reg signed [63:0] p;
        begin
            p = $signed(a) * $signed(b);
            q31_mul = p[31+`TSA_COMP_FRAC:`TSA_COMP_FRAC];
        end
    endfunction

    // Bus decode; upper address bits must be zero
    function hit;
        input [31:0] addr;
        input [13:0] idx;
        begin
            hit = (addr[31:16] == 16'h0000) && (addr[15:2] == idx);
        end
    endfunction

    reg [15:0] ext_temp_reg;
    reg [2:0]  src_sel_reg;
    reg [15:0] low_thr_reg;
    reg [15:0] high_thr_reg;
    reg [15:0] die_temp_reg;
    reg        alarm_live_reg;
    reg [7:0]  irq_stat_reg;
    reg [7:0]  irq_mask_reg;
    reg [31:0] coef0_reg;
    reg [31:0] coef1_reg;
    reg [31:0] coef2_reg;
    reg [31:0] coef3_reg;
    reg [31:0] coef4_reg;
    reg [31:0] coef5_reg;
    reg [1:0]  designate_reg;
    reg [31:0] tuning_reg;
    reg [31:0] fpe_reg;
    reg        wr_pend_reg;
    reg [31:0] wr_addr_reg;
    reg [7:0]  div_reg;
    reg [11:0] avg_cnt_reg;
    reg [27:0] avg_sum_reg;
    reg        sensor_upd_reg;
    reg        start_reg;
    reg [31:0] rdata_next;
    reg [7:0]  irq_stat_next;

    wire        addr_phase;
    wire        sample_now;
    wire [27:0] sum_with_sample;
    wire [15:0] sys_src;
    wire        ext_wr;
    wire [31:0] poly_result;
    wire        poly_done;
    wire [31:0] comp_neg;
    wire signed [64:0] tune_prod;
    wire [31:0] tune_corr;

    assign addr_phase = HSEL_I && HTRANS_I[1] && HREADY_I;

    // Sensor averaging
    assign sample_now      = (div_reg == SAMPLE_DIV_M1);
    assign sum_with_sample = avg_sum_reg + {{12{SENSOR_DATA_I[15]}}, SENSOR_DATA_I};

    always @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            div_reg        <= 8'h00;
            avg_cnt_reg    <= 12'h000;
            avg_sum_reg    <= 28'h0000000;
            die_temp_reg   <= 16'h0000;
            sensor_upd_reg <= 1'b0;
        end else begin
            sensor_upd_reg <= 1'b0;
            div_reg <= sample_now ? 8'h00 : div_reg + 8'h01;
            if (sample_now) begin
                if (avg_cnt_reg == AVG_LAST) begin
                    // Arithmetic shift keeps the signed 1/128 degree format
                    die_temp_reg   <= sum_with_sample[15+`TSA_AVG_LOG2:`TSA_AVG_LOG2];
                    sensor_upd_reg <= 1'b1;
                    avg_sum_reg    <= 28'h0000000;
                    avg_cnt_reg    <= 12'h000;
                end else begin
                    avg_sum_reg <= sum_with_sample;
                    avg_cnt_reg <= avg_cnt_reg + 12'h001;
                end
            end
        end
    end

    // Source routing, external value passes untouched
    assign sys_src = src_sel_reg[`TSA_SEL_SYS_BIT] ? ext_temp_reg : die_temp_reg;

    always @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            SYS_TEMP_O   <= 16'h0000;
            LOOP1_TEMP_O <= 16'h0000;
            LOOP2_TEMP_O <= 16'h0000;
        end else begin
            SYS_TEMP_O   <= sys_src;
            LOOP1_TEMP_O <= src_sel_reg[`TSA_SEL_LOOP1_BIT] ? ext_temp_reg : die_temp_reg;
            LOOP2_TEMP_O <= src_sel_reg[`TSA_SEL_LOOP2_BIT] ? ext_temp_reg : die_temp_reg;
        end
    end

    // Window detector, live and unlatched
    always @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            alarm_live_reg <= 1'b0;
            TEMP_ALARM_O   <= 1'b0;
        end else begin
            alarm_live_reg <= ($signed(die_temp_reg) > $signed(high_thr_reg)) ||
                              ($signed(die_temp_reg) < $signed(low_thr_reg));
            TEMP_ALARM_O   <= alarm_live_reg;
        end
    end

    // Compensation evaluation
    assign ext_wr = wr_pend_reg && hit(wr_addr_reg, `TSA_IDX_EXT_TEMP);

    always @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            start_reg <= 1'b0;
        end else begin
            // One cycle late so the new value has landed in its register
            start_reg <= src_sel_reg[`TSA_SEL_SYS_BIT] ? ext_wr : sensor_upd_reg;
        end
    end

    tsa_poly_eval tsa_poly_eval_inst (
        .clk_i    (REF_CLK_I),
        .rst_n_i  (RESETN_I),
        .start_i  (start_reg),
        .temp_i   (sys_src),
        .c0_i     (coef0_reg),
        .c1_i     (coef1_reg),
        .c2_i     (coef2_reg),
        .c3_i     (coef3_reg),
        .c4_i     (coef4_reg),
        .c5_i     (coef5_reg),
        .result_o (poly_result),
        .done_o   (poly_done)
    );

    // The term cancels the modelled source error
    assign comp_neg  = 32'h00000000 - poly_result;
    assign tune_prod = $signed({1'b0, tuning_reg}) * $signed(COMP_TERM_O);
    assign tune_corr = tune_prod[31+`TSA_COMP_FRAC:`TSA_COMP_FRAC];

    always @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            COMP_TERM_O  <= 32'h00000000;
            COMP_VALID_O <= 1'b0;
            fpe_reg      <= 32'h00000000;
            NCO_TUNING_O <= 32'h00000000;
            TDC_CORR_O   <= 32'h00000000;
        end else begin
            COMP_VALID_O <= poly_done;
            if (poly_done) begin
                COMP_TERM_O <= comp_neg;
                // Second order of -x/(1+x); the dropped term is below x cubed
                fpe_reg <= q31_mul(comp_neg, comp_neg) - comp_neg;
            end
            NCO_TUNING_O <= designate_reg[`TSA_DES_NCO_BIT] ?
                            tuning_reg + tune_corr : tuning_reg;
            TDC_CORR_O   <= designate_reg[`TSA_DES_TDC_BIT] ? fpe_reg : 32'h00000000;
        end
    end

    // Read mux, sampled in the address phase
    always @* begin
        rdata_next = 32'h00000000;
        if (hit(HADDR_I, `TSA_IDX_EXT_TEMP))    rdata_next = {16'h0000, ext_temp_reg};
        if (hit(HADDR_I, `TSA_IDX_SRC_SEL))     rdata_next = {29'h0000000, src_sel_reg};
        if (hit(HADDR_I, `TSA_IDX_LOW_THR))     rdata_next = {16'h0000, low_thr_reg};
        if (hit(HADDR_I, `TSA_IDX_HIGH_THR))    rdata_next = {16'h0000, high_thr_reg};
        if (hit(HADDR_I, `TSA_IDX_LIVE_STAT))   rdata_next = {31'h00000000, alarm_live_reg};
        if (hit(HADDR_I, `TSA_IDX_DIE_TEMP))    rdata_next = {16'h0000, die_temp_reg};
        if (hit(HADDR_I, `TSA_IDX_IRQ_STAT))    rdata_next = {24'h000000, irq_stat_reg};
        if (hit(HADDR_I, `TSA_IDX_IRQ_MASK))    rdata_next = {24'h000000, irq_mask_reg};
        if (hit(HADDR_I, `TSA_IDX_COEF0))       rdata_next = coef0_reg;
        if (hit(HADDR_I, `TSA_IDX_COEF1))       rdata_next = coef1_reg;
        if (hit(HADDR_I, `TSA_IDX_COEF2))       rdata_next = coef2_reg;
        if (hit(HADDR_I, `TSA_IDX_COEF3))       rdata_next = coef3_reg;
        if (hit(HADDR_I, `TSA_IDX_COEF4))       rdata_next = coef4_reg;
        if (hit(HADDR_I, `TSA_IDX_COEF5))       rdata_next = coef5_reg;
        if (hit(HADDR_I, `TSA_IDX_DESIGNATE))   rdata_next = {30'h00000000, designate_reg};
        if (hit(HADDR_I, `TSA_IDX_TUNING))      rdata_next = tuning_reg;
        if (hit(HADDR_I, `TSA_IDX_COMP_TERM))   rdata_next = COMP_TERM_O;
        if (hit(HADDR_I, `TSA_IDX_PERIOD_ERR))  rdata_next = fpe_reg;
    end

    // Status bit four is set by the live alarm and held until cleared; a set beats a same-cycle clear
    always @* begin
        irq_stat_next = irq_stat_reg;
        if (wr_pend_reg && hit(wr_addr_reg, `TSA_IDX_IRQ_STAT)) begin
            irq_stat_next = irq_stat_reg & ~HWDATA_I[7:0];
        end
        if (alarm_live_reg) begin
            irq_stat_next[`TSA_IRQ_TEMP_BIT] = 1'b1;
        end
    end

    // Zero-wait slave; every transfer answers OKAY
    always @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            HRDATA_O    <= 32'h00000000;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 32'h00000000;
            IRQ_O       <= 1'b0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            wr_pend_reg <= addr_phase && HWRITE_I;
            if (addr_phase) begin
                wr_addr_reg <= HADDR_I;
            end
            HRDATA_O <= (addr_phase && !HWRITE_I) ? rdata_next : 32'h00000000;
            IRQ_O    <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // Register writes in the data phase
    always @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ext_temp_reg  <= `TSA_RST_EXT_TEMP;
            src_sel_reg   <= `TSA_RST_SRC_SEL;
            low_thr_reg   <= `TSA_RST_LOW_THR;
            high_thr_reg  <= `TSA_RST_HIGH_THR;
            irq_stat_reg  <= 8'h00;
            irq_mask_reg  <= 8'h00;
            coef0_reg     <= 32'h00000000;
            coef1_reg     <= 32'h00000000;
            coef2_reg     <= 32'h00000000;
            coef3_reg     <= 32'h00000000;
            coef4_reg     <= 32'h00000000;
            coef5_reg     <= 32'h00000000;
            designate_reg <= 2'h0;
            tuning_reg    <= 32'h00000000;
        end else begin
            irq_stat_reg <= irq_stat_next;
            if (wr_pend_reg) begin
                if (hit(wr_addr_reg, `TSA_IDX_EXT_TEMP))  ext_temp_reg  <= HWDATA_I[15:0];
                if (hit(wr_addr_reg, `TSA_IDX_SRC_SEL))   src_sel_reg   <= HWDATA_I[2:0];
                if (hit(wr_addr_reg, `TSA_IDX_LOW_THR))   low_thr_reg   <= HWDATA_I[15:0];
                if (hit(wr_addr_reg, `TSA_IDX_HIGH_THR))  high_thr_reg  <= HWDATA_I[15:0];
                if (hit(wr_addr_reg, `TSA_IDX_IRQ_MASK))  irq_mask_reg  <= HWDATA_I[7:0];
                if (hit(wr_addr_reg, `TSA_IDX_COEF0))     coef0_reg     <= HWDATA_I;
                if (hit(wr_addr_reg, `TSA_IDX_COEF1))     coef1_reg     <= HWDATA_I;
                if (hit(wr_addr_reg, `TSA_IDX_COEF2))     coef2_reg     <= HWDATA_I;
                if (hit(wr_addr_reg, `TSA_IDX_COEF3))     coef3_reg     <= HWDATA_I;
                if (hit(wr_addr_reg, `TSA_IDX_COEF4))     coef4_reg     <= HWDATA_I;
                if (hit(wr_addr_reg, `TSA_IDX_COEF5))     coef5_reg     <= HWDATA_I;
                if (hit(wr_addr_reg, `TSA_IDX_DESIGNATE)) designate_reg <= HWDATA_I[1:0];
                if (hit(wr_addr_reg, `TSA_IDX_TUNING))    tuning_reg    <= HWDATA_I;
            end
        end
    end
endmodule

// >>> testbench/tsa_temp_comp_checker.sv
`timescale 1ns/10ps
module tsa_temp_comp_checker (
    input wire logic        REF_CLK_I,
    input wire logic        RESETN_I,
    input wire logic        HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic        HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic        HREADYOUT_O,
    input wire logic        HRESP_O,
    input wire logic        TEMP_ALARM_O,
    input wire logic [31:0] COMP_TERM_O,
    input wire logic        COMP_VALID_O,
    input wire logic [31:0] TDC_CORR_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESETN_I);
    sequence s_read_taken;
        HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I;
    endsequence
    sequence s_live_read;
        s_read_taken ##0 (HADDR_I == 32'h0000c008);
    endsequence
    a_ready_high: assert property (HREADYOUT_O == 1'b1)
        else $error("slave inserted a wait state");
    a_resp_okay: assert property (HRESP_O == 1'b0)
        else $error("slave gave an error response");
    a_rdata_idle: assert property (!(HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I)
        |=> HRDATA_O == 32'h0) else $error("read data not zero outside a read");
    a_unmapped_zero: assert property ((s_read_taken ##0 (HADDR_I[31:16] != 16'h0))
        |=> HRDATA_O == 32'h0) else $error("far address read not zero");
    a_alarm_read: assert property (s_live_read |=> HRDATA_O[0] == TEMP_ALARM_O)
        else $error("live alarm bit differs from alarm pin");
    a_valid_pulse: assert property (COMP_VALID_O |=> !COMP_VALID_O [*4])
        else $error("valid pulse too long or too frequent");
    a_term_valid: assert property ($changed(COMP_TERM_O) |-> COMP_VALID_O)
        else $error("term changed without valid");
    a_tdc_zero: assert property ((COMP_TERM_O == 32'h0) [*4] |-> TDC_CORR_O == 32'h0)
        else $error("period error nonzero with zero term");
endmodule

bind tsa_temp_comp tsa_temp_comp_checker tsa_temp_comp_checker_inst (
    .REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
    .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .TEMP_ALARM_O(TEMP_ALARM_O),
    .COMP_TERM_O(COMP_TERM_O), .COMP_VALID_O(COMP_VALID_O), .TDC_CORR_O(TDC_CORR_O)
);

// >>> testbench/tsa_temp_comp_test.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tsa_temp_comp_test;
    logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hready, hresp, valid, alarm, irq, al;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, term, nco, tdc, rd, t32, coef [6];
    logic [31:0] w = 32'h40000000;
    logic [15:0] sensor, sys_t, l1_t, l2_t, s, s2, e;
    logic [1:0]  htrans = 0;
    int          fail_count = 0, n_checks = 0, i, j, cnt;
    tsa_temp_comp tsa_temp_comp_inst (.REF_CLK_I(clk), .RESETN_I(rst_n), .HSEL_I(hsel),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
        .HRESP_O(hresp), .SENSOR_DATA_I(sensor), .SYS_TEMP_O(sys_t), .LOOP1_TEMP_O(l1_t),
        .LOOP2_TEMP_O(l2_t), .TEMP_ALARM_O(alarm), .IRQ_O(irq), .COMP_TERM_O(term),
        .COMP_VALID_O(valid), .NCO_TUNING_O(nco), .TDC_CORR_O(tdc));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= a;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] ex);
        bus(1'b0, a, 32'h0);
        `CHK(nm, ex, rd)
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge clk);
    endtask
    function automatic logic [31:0] term_exp(input logic [15:0] t);
        logic signed [63:0] acc;
        acc = signed'(coef[5]);
        for (int k = 4; k >= 0; k--)
            acc = ((acc * signed'(t)) >>> 7) + signed'(coef[k]);
        return -acc[31:0];
    endfunction
    function automatic logic [31:0] fpe_exp(input logic [31:0] x);
        logic signed [63:0] v;
        v = signed'(x);
        return 32'(((v * v) >>> 31) - v);
    endfunction
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #800000;
        fail_count++;
        test_done;
    end
    initial begin
        i = $urandom(32'hb8c68bb4);
        s = 16'($urandom_range(4095)) - 16'd2048 | 16'h1;
        e = s + 16'($urandom_range(1000) + 1);
        repeat (16) @(posedge clk);
        sensor <= s;
        rst_n <= 1'b1;
        rchk("sel rst", 32'ha408, 32'h0);
        rchk("low rst", 32'ha40c, 32'h8000);
        rchk("high rst", 32'ha414, 32'h7fff);
        rchk("irq rst", 32'hc030, 32'h0);
        rchk("far", 32'h0001a400, 32'h0);
        bus(1'b1, 32'ha400, {16'hffff, e});
        rchk("ext rw", 32'ha400, {16'h0, e});
        for (cnt = 0; cnt < 17000 && sys_t !== s; cnt++) @(negedge clk);
        `CHK("sensor path", s, sys_t)
        bus(1'b1, 32'hc00c, {16'h0, ~s});
        rchk("die temp", 32'hc00c, {16'h0, s});
        for (i = 0; i < 8; i++) begin
            bus(1'b1, 32'ha408, 32'(i));
            ticks(3);
            `CHK("sys", i[0] ? e : s, sys_t)
            `CHK("loop1", i[1] ? e : s, l1_t)
            `CHK("loop2", i[2] ? e : s, l2_t)
            rchk("sel rw", 32'ha408, 32'(i));
        end
        bus(1'b1, 32'ha408, 32'h0);
        // A limit equal to the reading must not alarm, so j=0 and j=2 probe the boundary
        for (j = 0; j < 4; j++) begin
            al = (j == 1 || j == 3);
            bus(1'b1, 32'ha440, j[1] ? 32'h10 : 32'h0);
            bus(1'b1, j[1] ? 32'ha40c : 32'ha414, {16'h0, 16'(s + 16'(j == 3) - 16'(j == 1))});
            ticks(4);
            `CHK("alarm pin", al, alarm)
            rchk("live", 32'hc008, {31'h0, al});
            bus(1'b1, 32'hc030, 32'h10);
            ticks(2);
            `CHK("irq pin", al & j[1], irq)
            rchk("sticky", 32'hc030, {27'h0, al, 4'h0});
            bus(1'b1, j[1] ? 32'ha40c : 32'ha414, j[1] ? 32'h8000 : 32'h7fff);
            bus(1'b1, 32'hc030, 32'h10);
            ticks(2);
            `CHK("irq low", 1'b0, irq)
            rchk("irq clr", 32'hc030, 32'h0);
        end
        s2 = s + 16'd100;
        @(posedge clk);
        sensor <= s2;
        for (cnt = 0; cnt < 40000 && sys_t !== s2; cnt++) @(negedge clk);
        `CHK("update gap", 1'b1, cnt > 16000 && cnt < 33000)
        for (cnt = 0; cnt < 40 && valid !== 1'b1; cnt++) @(negedge clk);
        `CHK("sensor restart", 1'b1, valid)
        rchk("die new", 32'hc00c, {16'h0, s2});
        bus(1'b1, 32'ha408, 32'h1);
        bus(1'b1, 32'ha4c4, w);
        for (i = 0; i < 4; i++) begin
            for (j = 0; j < 6; j++) begin
                coef[j] = (i == 0 && j > 0) ? 32'h0 : $urandom_range(8191) - 4096;
                coef[j][0] = coef[j][0] & (j != 0);
                bus(1'b1, 32'ha480 + 32'(4 * j), coef[j]);
            end
            bus(1'b1, 32'ha4c0, 32'(i));
            // Multiples of 256 keep every Horner shift exact and the term even
            e = 16'($urandom_range(7)) * 16'd256 - 16'd1024;
            bus(1'b1, 32'ha400, {16'h0, e});
            for (cnt = 0; cnt < 40 && valid !== 1'b1; cnt++) @(negedge clk);
            t32 = term_exp(e);
            `CHK("term", t32, term)
            ticks(4);
            `CHK("nco", i[0] ? w + {t32[31], t32[31:1]} : w, nco)
            `CHK("tdc", i[1] ? fpe_exp(t32) : 32'h0, tdc)
            rchk("term reg", 32'hc100, t32);
            rchk("fpe reg", 32'hc104, fpe_exp(t32));
        end
        test_done;
    end
endmodule
